// ===== dv/tcc_dma_model.sv
`timescale 1ns/10ps
module tcc_dma_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic top_irq_i,
  input wire logic load_i,
  input wire logic [7:0] len_i,
  input wire logic [15:0] mem_i,
  input wire logic [15:0] wdata_i,
  output logic ack_o,
  output logic eob_o,
  output logic [15:0] rdata_o,
  output logic [15:0] stored_o
);
  logic [7:0] cnt_reg;
  logic [7:0] addr_reg;
  logic [1:0] wait_reg;
  // ====
  // Serve one word per request, three cycles late
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 8'h00;
      addr_reg <= 8'h00;
      wait_reg <= 2'h0;
      ack_o <= 1'b0;
      eob_o <= 1'b0;
      rdata_o <= 16'h0000;
      stored_o <= 16'h0000;
    end else begin
      ack_o <= 1'b0;
      eob_o <= 1'b0;
      // Released data bus shows junk, not the last word
      rdata_o <= ~rdata_o;
      if (load_i) begin
        cnt_reg <= len_i;
        addr_reg <= 8'h00;
      end
      // A top-level interrupt holds off every DMA grant
      if (req_i && !ack_o && !top_irq_i) begin
        wait_reg <= wait_reg + 2'h1;
        if (wait_reg == 2'h2) begin
          wait_reg <= 2'h0;
          ack_o <= 1'b1;
          rdata_o <= mem_i;
          stored_o <= wdata_i;
          addr_reg <= addr_reg + 8'h01;
          cnt_reg <= cnt_reg - 8'h01;
          eob_o <= (cnt_reg == 8'h01);
        end
      end
    end
  end
endmodule

// ===== dv/timer_capture_compare_dma_request_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    miscompares++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); \
  end \
end
module timer_capture_compare_dma_request_tb;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cap_in = 1'b0, cmp_pin, req, is_cmp, irq;
  logic [15:0] wdata, rdata, stored, mem = 16'h0000;
  logic m_ack, m_eob, top_irq = 1'b0, ld = 1'b0;
  logic stray_ack = 1'b0, stray_eob = 1'b0;
  logic [7:0] len = 8'h01;
  int miscompares = 0;
  int checks_done = 0;

  always #25 clock_i = ~clock_i;

  tcc_top dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_in_i(cap_in), .compare_pin_o(cmp_pin), .dma_req_o(req),
    .dma_is_compare_o(is_cmp), .dma_wdata_o(wdata),
    .dma_ack_i(m_ack | stray_ack), .dma_rdata_i(rdata),
    .dma_eob_i(m_eob | stray_eob), .irq_o(irq));

  tcc_dma_model dma_u (.clk_i(clock_i), .rst_n_i(arst_n_i), .req_i(req),
    .top_irq_i(top_irq), .load_i(ld), .len_i(len), .mem_i(mem),
    .wdata_i(wdata), .ack_o(m_ack), .eob_o(m_eob), .rdata_o(rdata),
    .stored_o(stored));

  // ====
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic timeout(input string nm);
    miscompares++;
    $display("wrong value %s exp done got timeout", nm);
    conclude();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) timeout("pready");
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    checks_done++;
    while (s !== v && n < 300) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 300) timeout(nm);
  endtask

  task automatic pulse_cap();
    @(posedge clock_i);
    cap_in <= 1'b1;
    repeat (3) @(posedge clock_i);
    cap_in <= 1'b0;
  endtask

  // ====
  // Scenarios
  task automatic t_reset();
    apb(1'b0, tcc_pkg::ADDR_MASK_CTRL, 32'h0);
    `CHK("mask rst", {24'h0, tcc_pkg::MASK_CTRL_RESET}, rd)
    apb(1'b0, tcc_pkg::ADDR_COMPARE, 32'h0);
    `CHK("cmp rst", {16'h0, tcc_pkg::CMP_RESET}, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask

  task automatic t_cap_irq();
    apb(1'b1, tcc_pkg::ADDR_COUNTER, 32'h1234);
    apb(1'b1, tcc_pkg::ADDR_IRQ_MASK, 32'h1);
    // Run, capture enabled, capture on the falling edge
    apb(1'b1, tcc_pkg::ADDR_CTRL, 32'hb);
    pulse_cap();
    wait_lvl(irq, 1'b1, "cap irq");
    `CHK("no dma", 1'b0, req)
    apb(1'b1, tcc_pkg::ADDR_CAPTURE, 32'hffff);
    apb(1'b0, tcc_pkg::ADDR_CAPTURE, 32'h0);
    // The falling edge lands four ticks after the counter starts
    `CHK("capture", 32'h1238, rd)
    apb(1'b1, tcc_pkg::ADDR_IRQ_MASK, 32'h0);
    wait_lvl(irq, 1'b0, "masked");
    apb(1'b1, tcc_pkg::ADDR_IRQ_MASK, 32'h1);
    wait_lvl(irq, 1'b1, "unmasked");
    apb(1'b0, tcc_pkg::ADDR_IRQ_STATUS, 32'h0);
    `CHK("status", 1'b1, rd[tcc_pkg::ST_CAP_BIT])
    wait_lvl(irq, 1'b0, "read clear");
    // Stop the counter so the next scenario starts from a known count
    apb(1'b1, tcc_pkg::ADDR_CTRL, 32'h0);
  endtask

  task automatic t_cap_dma();
    ld <= 1'b1;
    top_irq <= 1'b1;
    apb(1'b1, tcc_pkg::ADDR_COUNTER, 32'h5a5a);
    ld <= 1'b0;
    apb(1'b1, tcc_pkg::ADDR_MASK_CTRL, 32'h1 << tcc_pkg::CAP_DMA_BIT);
    // Rising-edge capture lands one tick after the counter starts
    apb(1'b1, tcc_pkg::ADDR_CTRL, 32'h3);
    pulse_cap();
    wait_lvl(req, 1'b1, "cap req");
    repeat (10) @(posedge clock_i);
    `CHK("req stands", 1'b1, req)
    `CHK("store word", 16'h5a5b, wdata)
    `CHK("store dir", 1'b0, is_cmp)
    top_irq <= 1'b0;
    wait_lvl(req, 1'b0, "cap done");
    `CHK("stored", 16'h5a5b, stored)
    apb(1'b0, tcc_pkg::ADDR_MASK_CTRL, 32'h0);
    `CHK("mask eob", 32'h0, rd)
    apb(1'b0, tcc_pkg::ADDR_IRQ_STATUS, 32'h0);
    `CHK("no cap irq", 1'b0, rd[tcc_pkg::ST_CAP_BIT])
    pulse_cap();
    wait_lvl(irq, 1'b1, "back to irq");
    apb(1'b0, tcc_pkg::ADDR_IRQ_STATUS, 32'h0);
  endtask

  task automatic t_cmp_dma();
    mem <= 16'hbeef;
    len <= 8'h02;
    ld <= 1'b1;
    apb(1'b1, tcc_pkg::ADDR_COUNTER, 32'h0100);
    ld <= 1'b0;
    apb(1'b1, tcc_pkg::ADDR_COMPARE, 32'h0140);
    apb(1'b1, tcc_pkg::ADDR_MASK_CTRL, 32'h1 << tcc_pkg::CMP_DMA_BIT);
    apb(1'b1, tcc_pkg::ADDR_CTRL, 32'h5);
    wait_lvl(cmp_pin, 1'b1, "pin toggle");
    wait_lvl(m_ack, 1'b1, "cmp fetch");
    `CHK("fetch dir", 1'b1, is_cmp)
    apb(1'b1, tcc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, tcc_pkg::ADDR_COMPARE, 32'h0);
    `CHK("reload", 32'hbeef, rd)
    apb(1'b0, tcc_pkg::ADDR_MASK_CTRL, 32'h0);
    `CHK("mask kept", 32'h8, rd)
  endtask

  task automatic t_stray();
    apb(1'b1, tcc_pkg::ADDR_MASK_CTRL, 32'h48);
    stray_ack <= 1'b1;
    stray_eob <= 1'b1;
    @(posedge clock_i);
    stray_ack <= 1'b0;
    stray_eob <= 1'b0;
    apb(1'b0, tcc_pkg::ADDR_MASK_CTRL, 32'h0);
    `CHK("foreign eob", 32'h48, rd)
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_reset();
    t_cap_irq();
    t_cap_dma();
    t_cmp_dma();
    t_stray();
    conclude();
  end
endmodule

// ===== verilog/tcc_edge_det.sv
`timescale 1ns/10ps
module tcc_edge_det (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tcc_edge_if.det edge_io
);

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = edge_io.level;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign edge_io.rise_pulse = edge_io.level & ~prev_reg;
  assign edge_io.fall_pulse = ~edge_io.level & prev_reg;

endmodule

// ===== verilog/tcc_edge_if.sv
`timescale 1ns/10ps
interface tcc_edge_if;
  logic level;
  logic rise_pulse;
  logic fall_pulse;
  modport src (output level);
  modport det (input level, output rise_pulse, output fall_pulse);
  modport use_side (input rise_pulse, input fall_pulse);
endinterface

// ===== verilog/tcc_pkg.sv
package tcc_pkg;

  // ==========================================================
  // Register map (byte addresses on APB)
  // ==========================================================
  // The mask register sits at word index 0xff; the bus address is 4x that
  localparam logic [11:0] IDX_MASK_CTRL = 12'h0ff;
  localparam logic [11:0] ADDR_MASK_CTRL = {IDX_MASK_CTRL[9:0], 2'b00};
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CAPTURE = 12'h004;
  localparam logic [11:0] ADDR_COMPARE = 12'h008;
  localparam logic [11:0] ADDR_COUNTER = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

  // ==========================================================
  // Fields
  // ==========================================================
  localparam int CAP_DMA_BIT = 6;
  localparam int CMP_DMA_BIT = 3;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CAP_EN_BIT = 1;
  localparam int CTRL_CMP_EN_BIT = 2;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int ST_CAP_BIT = 0;
  localparam int ST_CMP_BIT = 1;
  localparam int ST_EOB_BIT = 2;

  localparam logic [7:0] MASK_CTRL_RESET = 8'h00;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    TCC_DMA_IDLE = 3'b001,
    TCC_DMA_CAP = 3'b010,
    TCC_DMA_CMP = 3'b100
  } tcc_dma_state_e;

endpackage

// ===== verilog/tcc_top.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module tcc_top (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_in_i,
  output logic compare_pin_o,
  output logic dma_req_o,
  output logic dma_is_compare_o,
  output logic [15:0] dma_wdata_o,
  input wire logic dma_ack_i,
  input wire logic [15:0] dma_rdata_i,
  input wire logic dma_eob_i,
  output logic irq_o
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] mask_ctrl_reg, mask_ctrl_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] cap_reg, cap_next;
  logic [15:0] cmp_reg, cmp_next;
  logic pin_reg, pin_next;
  logic [2:0] st_reg, st_next;
  logic [2:0] imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] dwdata_reg, dwdata_next;
  tcc_pkg::tcc_dma_state_e dma_reg, dma_next;

  // ==========================================================
  // Capture input edge
  // ==========================================================
  tcc_edge_if cap_edge ();
  assign cap_edge.level = capture_in_i;
  tcc_edge_det u_cap_edge (
    .clk_i(clock_i),
    .rst_n_i(rst_n),
    .edge_io(cap_edge)
  );

  logic running;
  logic cap_evt;
  logic cmp_evt;
  logic cap_dma;
  logic cmp_dma;
  logic wr_acc;
  logic rd_acc;
  logic eob_own;
  assign running = ctrl_reg[tcc_pkg::CTRL_RUN_BIT];
  assign cap_evt = running & ctrl_reg[tcc_pkg::CTRL_CAP_EN_BIT] &
    (ctrl_reg[tcc_pkg::CTRL_EDGE_BIT] ? cap_edge.fall_pulse
                                       : cap_edge.rise_pulse);
  assign cmp_evt = running & ctrl_reg[tcc_pkg::CTRL_CMP_EN_BIT] &
    (cnt_reg == cmp_reg);
  assign cap_dma = mask_ctrl_reg[tcc_pkg::CAP_DMA_BIT];
  assign cmp_dma = mask_ctrl_reg[tcc_pkg::CMP_DMA_BIT];
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  // End-of-block counts only while our own transfer is acknowledged
  assign eob_own = dma_ack_i & dma_eob_i &
    (dma_reg != tcc_pkg::TCC_DMA_IDLE);

  // ==========================================================
  // Timer datapath
  // ==========================================================
  always_comb begin
    cnt_next = running ? cnt_reg + tcc_pkg::CNT_STEP : cnt_reg;
    cap_next = cap_reg;
    cmp_next = cmp_reg;
    pin_next = pin_reg;
    if (cap_evt) begin
      cap_next = cnt_reg;
    end
    if (cmp_evt) begin
      pin_next = ~pin_reg;
    end
    if (dma_reg == tcc_pkg::TCC_DMA_CMP && dma_ack_i) begin
      cmp_next = dma_rdata_i;
    end
    if (wr_acc) begin
      case (paddr)
        tcc_pkg::ADDR_COUNTER: cnt_next = pwdata[15:0];
        tcc_pkg::ADDR_COMPARE: cmp_next = pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // DMA request sequencer
  // ==========================================================
  // One outstanding transfer; a new DMA event while busy is queued
  // only by taking the interrupt path, so nothing is dropped silently.
  always_comb begin
    dma_next = dma_reg;
    dwdata_next = dwdata_reg;
    case (dma_reg)
      tcc_pkg::TCC_DMA_IDLE: begin
        if (cap_evt && cap_dma) begin
          dma_next = tcc_pkg::TCC_DMA_CAP;
          dwdata_next = cnt_reg;
        end else if (cmp_evt && cmp_dma) begin
          dma_next = tcc_pkg::TCC_DMA_CMP;
        end
      end
      tcc_pkg::TCC_DMA_CAP, tcc_pkg::TCC_DMA_CMP: begin
        if (dma_ack_i) begin
          dma_next = tcc_pkg::TCC_DMA_IDLE;
        end
      end
      default: dma_next = tcc_pkg::TCC_DMA_IDLE;
    endcase
  end

  logic cap_to_irq;
  logic cmp_to_irq;
  assign cap_to_irq = cap_evt &
    (~cap_dma | (dma_reg != tcc_pkg::TCC_DMA_IDLE));
  assign cmp_to_irq = cmp_evt & (~cmp_dma |
    (dma_reg != tcc_pkg::TCC_DMA_IDLE) | (cap_evt & cap_dma));

  // ==========================================================
  // Mask, control and interrupt registers
  // ==========================================================
  always_comb begin
    mask_ctrl_next = mask_ctrl_reg;
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    st_next = st_reg;
    if (wr_acc) begin
      case (paddr)
        tcc_pkg::ADDR_MASK_CTRL: mask_ctrl_next = pwdata[7:0];
        tcc_pkg::ADDR_CTRL: ctrl_next = pwdata[3:0];
        tcc_pkg::ADDR_IRQ_MASK: imask_next = pwdata[2:0];
        default: ;
      endcase
    end
    if (eob_own && dma_reg == tcc_pkg::TCC_DMA_CAP) begin
      mask_ctrl_next[tcc_pkg::CAP_DMA_BIT] = 1'b0;
    end
    if (eob_own && dma_reg == tcc_pkg::TCC_DMA_CMP) begin
      mask_ctrl_next[tcc_pkg::CMP_DMA_BIT] = 1'b0;
    end
    if (rd_acc && paddr == tcc_pkg::ADDR_IRQ_STATUS) begin
      // Clear only bits the setup-cycle read reported, so an event
      // landing between setup and access is not lost
      st_next = st_reg & ~rdata_reg[tcc_pkg::ST_EOB_BIT:tcc_pkg::ST_CAP_BIT];
    end
    // Set wins over the read-clear
    if (cap_to_irq) begin
      st_next[tcc_pkg::ST_CAP_BIT] = 1'b1;
    end
    if (cmp_to_irq) begin
      st_next[tcc_pkg::ST_CMP_BIT] = 1'b1;
    end
    if (eob_own) begin
      st_next[tcc_pkg::ST_EOB_BIT] = 1'b1;
    end
  end

  // ==========================================================
  // APB read data
  // ==========================================================
  always_comb begin
    rdata_next = rdata_reg;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        tcc_pkg::ADDR_MASK_CTRL: rdata_next = {24'h000000, mask_ctrl_reg};
        tcc_pkg::ADDR_CTRL: rdata_next = {28'h0000000, ctrl_reg};
        tcc_pkg::ADDR_CAPTURE: rdata_next = {16'h0000, cap_reg};
        tcc_pkg::ADDR_COMPARE: rdata_next = {16'h0000, cmp_reg};
        tcc_pkg::ADDR_COUNTER: rdata_next = {16'h0000, cnt_reg};
        tcc_pkg::ADDR_IRQ_STATUS: rdata_next = {29'h00000000, st_reg};
        tcc_pkg::ADDR_IRQ_MASK: rdata_next = {29'h00000000, imask_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_ctrl_reg <= tcc_pkg::MASK_CTRL_RESET;
      ctrl_reg <= tcc_pkg::CTRL_RESET;
      cnt_reg <= tcc_pkg::CNT_RESET;
      cap_reg <= tcc_pkg::CNT_RESET;
      cmp_reg <= tcc_pkg::CMP_RESET;
      pin_reg <= 1'b0;
      st_reg <= 3'h0;
      imask_reg <= tcc_pkg::IRQ_MASK_RESET;
      rdata_reg <= 32'h00000000;
      dwdata_reg <= 16'h0000;
      dma_reg <= tcc_pkg::TCC_DMA_IDLE;
    end else begin
      mask_ctrl_reg <= mask_ctrl_next;
      ctrl_reg <= ctrl_next;
      cnt_reg <= cnt_next;
      cap_reg <= cap_next;
      cmp_reg <= cmp_next;
      pin_reg <= pin_next;
      st_reg <= st_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      dwdata_reg <= dwdata_next;
      dma_reg <= dma_next;
    end
  end

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_reg;
  assign compare_pin_o = pin_reg;
  assign dma_req_o = (dma_reg != tcc_pkg::TCC_DMA_IDLE);
  assign dma_is_compare_o = (dma_reg == tcc_pkg::TCC_DMA_CMP);
  assign dma_wdata_o = dwdata_reg;
  assign irq_o = |(st_reg & imask_reg);

  // ==========================================================
  // Assertions
  // ==========================================================
  // Every check lives in the one core clock domain
  default clocking cb_a @(posedge clock_i);
  endclocking
  default disable iff (!rst_n);

  a_capture_latch: assert property (cap_evt |=>
    cap_reg == $past(cnt_reg))
    else $error("capture did not latch counter");
  a_compare_toggle: assert property (cmp_evt |=>
    compare_pin_o != $past(compare_pin_o))
    else $error("compare pin did not toggle");
  a_event_handled: assert property (cap_evt |=>
    st_reg[tcc_pkg::ST_CAP_BIT] || dma_req_o)
    else $error("capture event went nowhere");
  a_status_sticky: assert property (st_reg[tcc_pkg::ST_CAP_BIT] &&
    !(rd_acc && paddr == tcc_pkg::ADDR_IRQ_STATUS) |=>
    st_reg[tcc_pkg::ST_CAP_BIT])
    else $error("capture status lost before read");
  a_cap_route_dma: assert property (cap_evt && cap_dma && !dma_req_o
    |=> dma_req_o && !dma_is_compare_o)
    else $error("capture not routed to dma");
  a_cmp_route_irq: assert property (cmp_evt && !cmp_dma |=>
    st_reg[tcc_pkg::ST_CMP_BIT])
    else $error("compare not routed to interrupt");
  a_cmp_route_dma: assert property (cmp_evt && cmp_dma && !dma_req_o
    && !(cap_evt && cap_dma) |=> dma_req_o && dma_is_compare_o)
    else $error("compare not routed to dma");
  a_one_transfer: assert property (dma_req_o && dma_ack_i |=>
    !dma_req_o)
    else $error("more than one transfer per event");
  a_reload_fetch: assert property (dma_is_compare_o && dma_ack_i &&
    !(wr_acc && paddr == tcc_pkg::ADDR_COMPARE) |=>
    cmp_reg == $past(dma_rdata_i))
    else $error("compare value not reloaded");
  a_eob_clears: assert property (eob_own && !dma_is_compare_o &&
    !(wr_acc && paddr == tcc_pkg::ADDR_MASK_CTRL) |=>
    !mask_ctrl_reg[tcc_pkg::CAP_DMA_BIT])
    else $error("end-of-block did not clear mask");
  a_foreign_eob: assert property (!dma_req_o && !wr_acc |=>
    mask_ctrl_reg == $past(mask_ctrl_reg))
    else $error("mask changed without own transfer");

  c_cap_dma: cover property (cap_evt && cap_dma);
  c_cmp_dma: cover property (dma_is_compare_o && dma_ack_i);
  c_eob: cover property (eob_own);
  c_irq: cover property (irq_o);
  c_cap_fall: cover property (cap_evt && ctrl_reg[tcc_pkg::CTRL_EDGE_BIT]);

endmodule
